// File: pmd_datapath.sv
/*
 Packed multiply datapath: decodes eight custom instructions, computes the
 result from two 64-bit sources and returns it one cycle later.
 Assumes the register file answers src1_idx/src2_idx combinationally in the
 issue cycle and the core writes res_data to res_rd when res_valid is high.
*/
`timescale 1ns/1ps
`default_nettype none
module pmd_datapath (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Issue
   input wire logic issue_valid,
   input wire logic [31:0] issue_instr,
   output logic op_hit,
   // Register file read
   output logic [pmd_pkg::IDX_W-1:0] src1_idx,
   output logic [pmd_pkg::IDX_W-1:0] src2_idx,
   input wire logic [63:0] src1_data,
   input wire logic [63:0] src2_data,
   // Result
   output logic res_valid,
   output logic [pmd_pkg::IDX_W-1:0] res_rd,
   output logic [63:0] res_data,
   // Overflow flag
   input wire logic overflow_clr,
   output logic overflow_flag
);
   import pmd_pkg::*;

   // Maps the function field onto an operation
   function automatic pmd_op_t decode_op(input logic [6:0] f7);
      pmd_op_t op;
      case (f7)
         F7_HALF_MUL_ADD: op = PMD_OP_MADD;
         F7_HALF_XMUL_ADD: op = PMD_OP_XMADD;
         F7_HALF_MUL_RSUB: op = PMD_OP_RSUB;
         F7_HALF_XMUL_SUB: op = PMD_OP_XSUB;
         F7_LOW_LOW: op = PMD_OP_LL;
         F7_LOW_LOW_SHR14: op = PMD_OP_LL14;
         F7_LOW_LOW_SHR32: op = PMD_OP_LL32;
         F7_LOW_HIGH: op = PMD_OP_LH;
         default: op = PMD_OP_NONE;
      endcase
      return op;
   endfunction : decode_op

   // One 32-bit lane of a halfword operation; bit 32 is the saturation mark
   function automatic logic [32:0] lane_calc(input pmd_op_t op, input logic [31:0] a,
                                             input logic [31:0] b);
      logic signed [31:0] p_hh;
      logic signed [31:0] p_ll;
      logic signed [31:0] p_hl;
      logic signed [31:0] p_lh;
      logic sat;
      logic [32:0] r;
      p_hh = $signed(a[31:16]) * $signed(b[31:16]);
      p_ll = $signed(a[15:0]) * $signed(b[15:0]);
      p_hl = $signed(a[31:16]) * $signed(b[15:0]);
      p_lh = $signed(a[15:0]) * $signed(b[31:16]);
      sat = (a == SAT_PATTERN) && (b == SAT_PATTERN);
      case (op)
         PMD_OP_MADD: r = sat ? {1'b1, SAT_VALUE} : {1'b0, p_hh + p_ll};
         PMD_OP_XMADD: r = sat ? {1'b1, SAT_VALUE} : {1'b0, p_hl + p_lh};
         PMD_OP_RSUB: r = {1'b0, p_ll - p_hh};
         PMD_OP_XSUB: r = {1'b0, p_hl - p_lh};
         default: r = 33'h0;
      endcase
      return r;
   endfunction : lane_calc

   // Decode
   wire [6:0] f7 = issue_instr[F7_LSB +: F7_W];
   wire [2:0] f3 = issue_instr[F3_LSB +: F3_W];
   wire [6:0] opc = issue_instr[OPC_LSB +: OPC_W];
   pmd_op_t op;
   assign op = decode_op(f7);
   wire op_match = (opc == OPC_CUSTOM3) && (f3 == F3_ZERO) && (op != PMD_OP_NONE);
   wire take = issue_valid && op_match;
   wire [IDX_W-1:0] rd_idx = issue_instr[RD_LSB +: IDX_W];

   assign op_hit = take;
   assign src1_idx = issue_instr[RS1_LSB +: IDX_W];
   assign src2_idx = issue_instr[RS2_LSB +: IDX_W];

   // Halfword lanes
   wire [32:0] lane0 = lane_calc(op, src1_data[31:0], src2_data[31:0]);
   wire [32:0] lane1 = lane_calc(op, src1_data[63:32], src2_data[63:32]);
   wire half_op = (op == PMD_OP_MADD) || (op == PMD_OP_XMADD) ||
                  (op == PMD_OP_RSUB) || (op == PMD_OP_XSUB);
   wire sat_any = lane0[32] || lane1[32];

   // Word multiply
   wire [31:0] word_b = (op == PMD_OP_LH) ? src2_data[63:32] : src2_data[31:0];
   wire signed [63:0] wprod = $signed(src1_data[31:0]) * $signed(word_b);
   wire [63:0] word_res = (op == PMD_OP_LL14) ? 64'(wprod >>> SHIFT_A) :
                          (op == PMD_OP_LL32) ? 64'(wprod >>> SHIFT_B) :
                          64'(wprod);

   logic res_valid_ff;
   logic [IDX_W-1:0] res_rd_ff;
   logic [63:0] res_data_ff;
   logic overflow_ff;

   wire [63:0] nxt_res_data = half_op ? {lane1[31:0], lane0[31:0]} : word_res;
   wire nxt_overflow = (take && sat_any) || (overflow_ff && !overflow_clr);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         res_valid_ff <= 1'b0;
         res_rd_ff <= RES_RD_RST;
         res_data_ff <= RES_DATA_RST;
         overflow_ff <= OV_RST;
      end else begin
         res_valid_ff <= take;
         overflow_ff <= nxt_overflow;
         if (take) begin
            res_rd_ff <= rd_idx;
            res_data_ff <= nxt_res_data;
         end
      end
   end

   assign res_valid = res_valid_ff;
   assign res_rd = res_rd_ff;
   assign res_data = res_data_ff;
   assign overflow_flag = overflow_ff;

   // Checks
   property p_decode;
      @(posedge sys_clk) disable iff (!rstn)
      op_hit |-> (issue_instr[6:0] == 7'h7B) && (issue_instr[14:12] == 3'h0);
   endproperty
   a_decode: assert property (p_decode) else $error("hit without custom-3 and funct3 zero");

   property p_latency;
      @(posedge sys_clk) disable iff (!rstn)
      op_hit |=> res_valid && (res_rd == $past(issue_instr[11:7]));
   endproperty
   a_latency: assert property (p_latency) else $error("result not returned next cycle");

   property p_madd;
      @(posedge sys_clk) disable iff (!rstn)
      (op_hit && issue_instr[31:25] == 7'h32 && src1_data[31:0] != 32'h80008000) |=>
      res_data[31:0] == 32'($signed($past(src1_data[31:16])) * $signed($past(src2_data[31:16]))
                           + $signed($past(src1_data[15:0])) * $signed($past(src2_data[15:0])));
   endproperty
   a_madd: assert property (p_madd) else $error("multiply-add lane wrong");

   property p_sat;
      @(posedge sys_clk) disable iff (!rstn)
      (op_hit && issue_instr[31:26] == 6'h19 &&
       src1_data[63:32] == 32'h80008000 && src2_data[63:32] == 32'h80008000) |=>
      (res_data[63:32] == 32'h7FFFFFFF) && overflow_flag;
   endproperty
   a_sat: assert property (p_sat) else $error("saturation lane wrong");

   property p_ov_hold;
      @(posedge sys_clk) disable iff (!rstn)
      (overflow_flag && !overflow_clr) |=> overflow_flag;
   endproperty
   a_ov_hold: assert property (p_ov_hold) else $error("overflow flag lost");

   property p_ov_rise;
      @(posedge sys_clk) disable iff (!rstn)
      $rose(overflow_flag) |-> $past(op_hit) && $past(issue_instr[31:26] == 6'h19);
   endproperty
   a_ov_rise: assert property (p_ov_rise) else $error("overflow set without saturating op");

   property p_rsub;
      @(posedge sys_clk) disable iff (!rstn)
      (op_hit && issue_instr[31:25] == 7'h34) |=>
      res_data[31:0] == 32'($signed($past(src1_data[15:0])) * $signed($past(src2_data[15:0]))
                           - $signed($past(src1_data[31:16])) * $signed($past(src2_data[31:16])));
   endproperty
   a_rsub: assert property (p_rsub) else $error("reverse subtract lane wrong");

   property p_ll14;
      @(posedge sys_clk) disable iff (!rstn)
      (op_hit && issue_instr[31:25] == 7'h37) |=>
      res_data == 64'(($signed($past(src1_data[31:0])) * $signed($past(src2_data[31:0]))) >>> 14);
   endproperty
   a_ll14: assert property (p_ll14) else $error("shift-14 product wrong");

   property p_ll32;
      @(posedge sys_clk) disable iff (!rstn)
      (op_hit && issue_instr[31:25] == 7'h38) |=>
      res_data == 64'(($signed($past(src1_data[31:0])) * $signed($past(src2_data[31:0]))) >>> 32);
   endproperty
   a_ll32: assert property (p_ll32) else $error("shift-32 product wrong");

   property p_lh;
      @(posedge sys_clk) disable iff (!rstn)
      (op_hit && issue_instr[31:25] == 7'h39) |=>
      res_data == 64'($signed($past(src1_data[31:0])) * $signed($past(src2_data[63:32])));
   endproperty
   a_lh: assert property (p_lh) else $error("low-by-high product wrong");

   property p_idle;
      @(posedge sys_clk) disable iff (!rstn)
      !op_hit |=> !res_valid;
   endproperty
   a_idle: assert property (p_idle) else $error("result without issue");

   c_sat: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(overflow_flag));
   c_clr: cover property (@(posedge sys_clk) disable iff (!rstn) $fell(overflow_flag));
   c_b2b: cover property (@(posedge sys_clk) disable iff (!rstn) op_hit ##1 op_hit);
endmodule : pmd_datapath
`default_nettype wire

// File: pmd_datapath_tb.sv
/*
 Self-checking bench for the packed multiply datapath.
 Assumes the register file model answers reads in the issue cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module pmd_datapath_tb;
   import pmd_pkg::*;
   logic sys_clk = 1'b0, rstn = 1'b0, issue_valid = 1'b0, overflow_clr = 1'b0;
   logic [31:0] issue_instr = 32'h0;
   logic op_hit, res_valid, overflow_flag, ld_en = 1'b0;
   logic [4:0] src1_idx, src2_idx, res_rd, ld_idx = 5'h0;
   logic [63:0] src1_data, src2_data, res_data, ld_data = 64'h0;
   int failures = 0, samples_checked = 0, cycles = 0;
   always #50 sys_clk = ~sys_clk;
   pmd_datapath i_dut (.sys_clk(sys_clk), .rstn(rstn), .issue_valid(issue_valid),
      .issue_instr(issue_instr), .op_hit(op_hit), .src1_idx(src1_idx), .src2_idx(src2_idx),
      .src1_data(src1_data), .src2_data(src2_data), .res_valid(res_valid), .res_rd(res_rd),
      .res_data(res_data), .overflow_clr(overflow_clr), .overflow_flag(overflow_flag));
   pmd_regfile_model i_rf (.sys_clk(sys_clk), .rd_idx_a(src1_idx), .rd_idx_b(src2_idx),
      .rd_data_a(src1_data), .rd_data_b(src2_data), .wr_en(res_valid), .wr_idx(res_rd),
      .wr_data(res_data), .ld_en(ld_en), .ld_idx(ld_idx), .ld_data(ld_data));
   task automatic test_done();
      if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         test_done();
      end
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [31:0] hp(input logic [15:0] x, input logic [15:0] y);
      logic signed [31:0] p;
      p = $signed(x) * $signed(y);
      return p;
   endfunction : hp
   function automatic logic [63:0] wm(input logic [31:0] x, input logic [31:0] y);
      logic signed [63:0] p;
      p = $signed(x) * $signed(y);
      return p;
   endfunction : wm
   function automatic logic [31:0] lane(input int op, input logic [31:0] x, input logic [31:0] y);
      case (op)
         0: return hp(x[31:16], y[31:16]) + hp(x[15:0], y[15:0]);
         1: return hp(x[31:16], y[15:0]) + hp(x[15:0], y[31:16]);
         2: return hp(x[15:0], y[15:0]) - hp(x[31:16], y[31:16]);
         default: return hp(x[31:16], y[15:0]) - hp(x[15:0], y[31:16]);
      endcase
   endfunction : lane
   function automatic logic [63:0] pair(input int op, input logic [63:0] a, input logic [63:0] b);
      return {lane(op, a[63:32], b[63:32]), lane(op, a[31:0], b[31:0])};
   endfunction : pair
   task automatic load(input logic [4:0] idx, input logic [63:0] d);
      @(posedge sys_clk) #1 ld_en = 1'b1;
      ld_idx = idx;
      ld_data = d;
      @(posedge sys_clk) #1 ld_en = 1'b0;
   endtask : load
   task automatic issue(input logic [6:0] f7, input logic [2:0] f3, input logic [6:0] opc,
         input logic [63:0] a, input logic [63:0] b, output logic hit);
      load(5'h1, a);
      load(5'h2, b);
      issue_instr = {f7, 5'h2, 5'h1, f3, 5'h3, opc};
      issue_valid = 1'b1;
      @(posedge sys_clk) hit = op_hit;
      chk({54'h0, src2_idx, src1_idx}, 64'h41);
      #1 issue_valid = 1'b0;
   endtask : issue
   task automatic do_op(input logic [6:0] f7, input logic [63:0] a, input logic [63:0] b,
         input logic [63:0] exp);
      logic hit;
      issue(f7, F3_ZERO, OPC_CUSTOM3, a, b, hit);
      chk({57'h0, hit, res_valid, res_rd}, 64'h63);
      chk(res_data, exp);
   endtask : do_op
   task automatic t_half_add();
      logic [63:0] a, b;
      a = 64'h80008000_7FFF8001;
      b = 64'h7FFF8000_80007FFF;
      do_op(F7_HALF_MUL_ADD, a, b, pair(0, a, b));
      do_op(F7_HALF_XMUL_ADD, a, b, pair(1, a, b));
      chk({63'h0, overflow_flag}, 64'h0);
      a = 64'h80008000_0003FFFC;
      b = 64'h80008000_FFFF0005;
      do_op(F7_HALF_MUL_ADD, a, b, {32'h7FFFFFFF, lane(0, a[31:0], b[31:0])});
      chk({63'h0, overflow_flag}, 64'h1);
      do_op(F7_HALF_XMUL_ADD, b, b, {32'h7FFFFFFF, lane(1, b[31:0], b[31:0])});
      do_op(F7_HALF_MUL_RSUB, a, b, pair(2, a, b));
      chk({63'h0, overflow_flag}, 64'h1);
      @(posedge sys_clk) #1 overflow_clr = 1'b1;
      @(posedge sys_clk) #1 overflow_clr = 1'b0;
      chk({63'h0, overflow_flag}, 64'h0);
      do_op(F7_HALF_XMUL_ADD, {a[31:0], a[63:32]}, {b[31:0], b[63:32]},
         {lane(1, a[31:0], b[31:0]), 32'h7FFFFFFF});
      chk({63'h0, overflow_flag}, 64'h1);
      // Clear held across a saturating issue: the set must win
      overflow_clr = 1'b1;
      do_op(F7_HALF_MUL_ADD, a, b, {32'h7FFFFFFF, lane(0, a[31:0], b[31:0])});
      overflow_clr = 1'b0;
      chk({63'h0, overflow_flag}, 64'h1);
   endtask : t_half_add
   task automatic t_half_sub();
      logic [63:0] a, b;
      a = 64'h7FFF8000_80007FFF;
      b = 64'h80008000_1234EDCB;
      do_op(F7_HALF_MUL_RSUB, a, b, pair(2, a, b));
      do_op(F7_HALF_XMUL_SUB, a, b, pair(3, a, b));
   endtask : t_half_sub
   task automatic t_words();
      logic [63:0] a, b, p;
      a = 64'hAAAA5555_87654321;
      b = 64'h12345678_FEDCBA98;
      p = wm(a[31:0], b[31:0]);
      do_op(F7_LOW_LOW, a, b, p);
      do_op(F7_LOW_LOW_SHR14, a, b, $signed(p) >>> 14);
      do_op(F7_LOW_LOW_SHR32, a, b, $signed(p) >>> 32);
      do_op(F7_LOW_HIGH, a, b, wm(a[31:0], b[63:32]));
   endtask : t_words
   task automatic t_b2b();
      logic [63:0] a, b;
      a = 64'h00030004_FFFE0007;
      b = 64'h00050006_0009FFF8;
      load(5'h1, a);
      load(5'h2, b);
      issue_instr = {F7_HALF_MUL_ADD, 5'h2, 5'h1, F3_ZERO, 5'h4, OPC_CUSTOM3};
      issue_valid = 1'b1;
      @(posedge sys_clk) #1 issue_instr = {F7_LOW_LOW, 5'h2, 5'h1, F3_ZERO, 5'h5, OPC_CUSTOM3};
      chk({58'h0, res_valid, res_rd}, 64'h24);
      chk(res_data, pair(0, a, b));
      @(posedge sys_clk) #1 issue_valid = 1'b0;
      chk({58'h0, res_valid, res_rd}, 64'h25);
      chk(res_data, wm(a[31:0], b[31:0]));
      @(posedge sys_clk) #1;
      chk({63'h0, res_valid}, 64'h0);
   endtask : t_b2b
   task automatic t_refuse();
      logic hit;
      issue(F7_LOW_LOW, 3'h1, OPC_CUSTOM3, 64'h1, 64'h1, hit);
      chk({62'h0, hit, res_valid}, 64'h0);
      issue(F7_LOW_LOW, F3_ZERO, 7'h7A, 64'h1, 64'h1, hit);
      chk({62'h0, hit, res_valid}, 64'h0);
      issue(7'h3A, F3_ZERO, OPC_CUSTOM3, 64'h1, 64'h1, hit);
      chk({62'h0, hit, res_valid}, 64'h0);
      issue(7'h31, F3_ZERO, OPC_CUSTOM3, 64'h1, 64'h1, hit);
      chk({61'h0, hit, res_valid, overflow_flag}, 64'h1);
   endtask : t_refuse
   initial begin
      repeat (10) @(posedge sys_clk);
      chk({57'h0, res_valid, overflow_flag, res_rd}, 64'h0);
      chk(res_data, 64'h0);
      #1 rstn = 1'b1;
      t_half_add();
      t_half_sub();
      t_words();
      t_b2b();
      t_refuse();
      test_done();
   end
endmodule : pmd_datapath_tb
`default_nettype wire

// File: pmd_pkg.sv
/*
 Constants, field positions and the operation type of the packed multiply datapath.
 Assumes 32-bit instructions and 64-bit register file words.
*/
`default_nettype none
package pmd_pkg;
   // Instruction field positions and widths
   localparam int OPC_LSB = 0;
   localparam int OPC_W = 7;
   localparam int RD_LSB = 7;
   localparam int F3_LSB = 12;
   localparam int F3_W = 3;
   localparam int RS1_LSB = 15;
   localparam int RS2_LSB = 20;
   localparam int F7_LSB = 25;
   localparam int F7_W = 7;
   localparam int IDX_W = 5;
   // Match values
   localparam logic [6:0] OPC_CUSTOM3 = 7'h7B;
   localparam logic [2:0] F3_ZERO = 3'h0;
   localparam logic [6:0] F7_HALF_MUL_ADD = 7'h32;
   localparam logic [6:0] F7_HALF_XMUL_ADD = 7'h33;
   localparam logic [6:0] F7_HALF_MUL_RSUB = 7'h34;
   localparam logic [6:0] F7_HALF_XMUL_SUB = 7'h35;
   localparam logic [6:0] F7_LOW_LOW = 7'h36;
   localparam logic [6:0] F7_LOW_LOW_SHR14 = 7'h37;
   localparam logic [6:0] F7_LOW_LOW_SHR32 = 7'h38;
   localparam logic [6:0] F7_LOW_HIGH = 7'h39;
   // Saturation
   localparam logic [31:0] SAT_PATTERN = 32'h80008000;
   localparam logic [31:0] SAT_VALUE = 32'h7FFFFFFF;
   // Shift amounts
   localparam int SHIFT_A = 14;
   localparam int SHIFT_B = 32;
   // Reset values
   localparam logic [63:0] RES_DATA_RST = 64'h0;
   localparam logic [4:0] RES_RD_RST = 5'h0;
   localparam logic OV_RST = 1'b0;

   typedef enum logic [3:0] {
      PMD_OP_NONE,
      PMD_OP_MADD,
      PMD_OP_XMADD,
      PMD_OP_RSUB,
      PMD_OP_XSUB,
      PMD_OP_LL,
      PMD_OP_LL14,
      PMD_OP_LL32,
      PMD_OP_LH
   } pmd_op_t;
endpackage : pmd_pkg
`default_nettype wire

// File: pmd_regfile_model.sv
/*
 Behavioural register file facing the packed multiply datapath.
 Assumes one clock; reads are combinational, writes land on the rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pmd_regfile_model (
   // Clock
   input wire logic sys_clk,
   // Read ports
   input wire logic [4:0] rd_idx_a,
   input wire logic [4:0] rd_idx_b,
   output logic [63:0] rd_data_a,
   output logic [63:0] rd_data_b,
   // Result write
   input wire logic wr_en,
   input wire logic [4:0] wr_idx,
   input wire logic [63:0] wr_data,
   // Preload
   input wire logic ld_en,
   input wire logic [4:0] ld_idx,
   input wire logic [63:0] ld_data
);
   logic [63:0] regs_ff [32];
   assign rd_data_a = regs_ff[rd_idx_a];
   assign rd_data_b = regs_ff[rd_idx_b];
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         regs_ff[wr_idx] <= wr_data;
      end
      if (ld_en) begin
         regs_ff[ld_idx] <= ld_data;
      end
   end
endmodule : pmd_regfile_model
`default_nettype wire
